// >>> design/lsi_top.v
// Purpose: Zero-crossing timeout, period, sag, peak and interrupt logic
// Assumes: Samples come from same-clock filter logic; supply_low is a pin
// Notes:   Register access is framed: reg_rd at command end, reg_rd_done
//          when the last data bit has been shifted out
`timescale 1ns/1ps
`default_nettype none
`include "lsi_defs.vh"

module lsi_top #(
    parameter TIMEOUT_W = 12,
    parameter PERIOD_W = 16,
    parameter LP_W = 16,
    parameter WAVE_W = 24
) (
    input wire clk,
    input wire rstn,
    input wire [LP_W-1:0] vlp_sample,
    input wire vlp_valid,
    input wire [WAVE_W-1:0] v_sample,
    input wire [WAVE_W-1:0] i_sample,
    input wire wave_valid,
    input wire supply_low,
    input wire [`LSI_ADDR_W-1:0] reg_addr,
    input wire reg_wr,
    input wire [15:0] reg_wdata,
    input wire reg_rd,
    input wire reg_rd_done,
    output reg [WAVE_W-1:0] reg_rdata,
    output reg irq_n,
    output reg sag_n,
    output reg crossing_indicator,
    output reg energy_hold
);

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function [WAVE_W-1:0] abs_wave;
        input [WAVE_W-1:0] x;
        begin
            abs_wave = x[WAVE_W-1] ? (~x + {{(WAVE_W-1){1'b0}}, 1'b1}) : x;
        end
    endfunction

    // Top byte of twice the magnitude
    function [7:0] dbl_top;
        input [WAVE_W-1:0] mag;
        begin
            dbl_top = mag[WAVE_W-2:WAVE_W-9];
        end
    endfunction

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    reg [15:0] mode;
    reg [15:0] irq_enable;
    reg [15:0] event_flags;
    reg [TIMEOUT_W-1:0] crossing_timeout;
    reg [7:0] sag_cycle_count;
    reg [7:0] sag_threshold;
    reg [7:0] voltage_peak_level;
    reg [7:0] current_peak_level;
    reg [WAVE_W-1:0] voltage_peak_record;
    reg [WAVE_W-1:0] current_peak_record;
    reg [PERIOD_W-1:0] line_period;

    reg supply_meta;
    reg supply_sync;
    reg [6:0] div_cnt;
    reg [TIMEOUT_W-1:0] timeout_cnt;
    reg timeout_active;
    reg prev_sign;
    reg sign_seen;
    reg [2:0] per_div;
    reg [PERIOD_W-2:0] per_cnt;
    reg [7:0] sag_cnt;
    reg cyc_above;
    reg sag_active;
    reg rd_busy;
    reg [`LSI_ADDR_W-1:0] rd_addr;
    reg [15:0] status_snap;
    // Events raised after the snapshot, kept through the clear
    reg [15:0] rd_events;

    wire sag_dis = mode[`LSI_MODE_SAG_DIS];
    wire tick_128 = (div_cnt == 7'h7F);
    wire per_tick = (per_div == 3'h7);

    // ------------------------------------------------------------
    // Zero crossing
    // ------------------------------------------------------------
    wire lp_sign = vlp_sample[LP_W-1];
    wire crossing = vlp_valid & sign_seen & (lp_sign != prev_sign);
    wire pos_crossing = crossing & ~lp_sign;
    wire [LP_W-1:0] lp_mag = lp_sign ? (~vlp_sample + {{(LP_W-1){1'b0}}, 1'b1}) : vlp_sample;
    // Magnitude shifted left one, most significant byte
    wire [7:0] lp_top = lp_mag[LP_W-2:LP_W-9];
    // Levels 0 and 1 both mean a zero threshold
    wire [7:0] sag_eff = (sag_threshold <= 8'h01) ? 8'h00 : sag_threshold;
    wire lp_below = vlp_valid & (sag_eff > lp_top);
    wire lp_above = vlp_valid & (lp_top > sag_eff);

    // ------------------------------------------------------------
    // Events
    // ------------------------------------------------------------
    wire timeout_event = tick_128 & ~crossing & (timeout_cnt == {{(TIMEOUT_W-1){1'b0}}, 1'b1});
    wire [7:0] next_sag_cnt = sag_cnt + 8'h01;
    // A full cycle counts only when no sample rose above the level
    wire cycle_low = pos_crossing & ~cyc_above & ~lp_above;
    wire sag_event = cycle_low & ~sag_active & (next_sag_cnt == sag_cycle_count - 8'h01);
    wire [WAVE_W-1:0] v_mag = abs_wave(v_sample);
    wire [WAVE_W-1:0] i_mag = abs_wave(i_sample);
    wire vpk_event = wave_valid & (dbl_top(v_mag) > voltage_peak_level);
    wire ipk_event = wave_valid & (dbl_top(i_mag) > current_peak_level);
    wire [WAVE_W-1:0] v_dbl = {v_mag[WAVE_W-2:0], 1'b0};

    reg [15:0] event_set;
    always @* begin
        event_set = 16'h0000;
        event_set[`LSI_BIT_TIMEOUT] = timeout_event;
        event_set[`LSI_BIT_SAG] = sag_event;
        event_set[`LSI_BIT_CROSSING] = crossing;
        event_set[`LSI_BIT_VOLTAGE_PEAK_RECORD] = vpk_event;
        event_set[`LSI_BIT_CURRENT_PEAK_RECORD] = ipk_event;
    end

    // ------------------------------------------------------------
    // Read framing
    // ------------------------------------------------------------
    wire rd_end = rd_busy & reg_rd_done;
    wire clr_status = rd_end & (rd_addr == `LSI_A_STATUS_RC);
    wire clr_voltage_peak_record = rd_end & (rd_addr == `LSI_A_VOLTAGE_PEAK_RECORD_RC);
    wire clr_current_peak_record = rd_end & (rd_addr == `LSI_A_CURRENT_PEAK_RECORD_RC);
    wire status_rd_start = reg_rd & (reg_addr == `LSI_A_STATUS_RC);

    // Only flags the host has actually seen are cleared, so an event
    // landing during the data transfer survives the clear, even when
    // it repeats a flag that was already in the snapshot
    wire [15:0] next_flags = (clr_status ? ((event_flags & ~status_snap) | rd_events)
                             : event_flags) | event_set;
    wire hold_high = status_rd_start | (rd_busy & ~reg_rd_done
                     & (rd_addr == `LSI_A_STATUS_RC));

    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            supply_meta <= 1'b0;
            supply_sync <= 1'b0;
        end else begin
            supply_meta <= supply_low;
            supply_sync <= supply_meta;
        end
    end

    // ------------------------------------------------------------
    // Host writes
    // ------------------------------------------------------------
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            mode <= `LSI_MODE_RST;
            irq_enable <= `LSI_IRQ_ENABLE_RST;
            crossing_timeout <= `LSI_TIMEOUT_RST;
            sag_cycle_count <= `LSI_SAG_CYC_RST;
            sag_threshold <= `LSI_SAG_LVL_RST;
            voltage_peak_level <= `LSI_PK_LVL_RST;
            current_peak_level <= `LSI_PK_LVL_RST;
        end else if (reg_wr) begin
            case (reg_addr)
                `LSI_A_MODE: mode <= reg_wdata;
                `LSI_A_IRQ_ENABLE: irq_enable <= reg_wdata;
                `LSI_A_TIMEOUT: crossing_timeout <= reg_wdata[TIMEOUT_W-1:0];
                `LSI_A_SAG_CYC: sag_cycle_count <= reg_wdata[7:0];
                `LSI_A_SAG_LVL: sag_threshold <= reg_wdata[7:0];
                `LSI_A_VPK_LVL: voltage_peak_level <= reg_wdata[7:0];
                `LSI_A_IPK_LVL: current_peak_level <= reg_wdata[7:0];
                default: mode <= mode;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Host reads
    // ------------------------------------------------------------
    reg [WAVE_W-1:0] next_rdata;
    always @* begin
        case (reg_addr)
            `LSI_A_MODE: next_rdata = {8'h00, mode};
            `LSI_A_IRQ_ENABLE: next_rdata = {8'h00, irq_enable};
            `LSI_A_EVENT_FLAGS: next_rdata = {8'h00, event_flags};
            `LSI_A_STATUS_RC: next_rdata = {8'h00, event_flags};
            `LSI_A_TIMEOUT: next_rdata = {12'h000, crossing_timeout};
            `LSI_A_SAG_CYC: next_rdata = {16'h0000, sag_cycle_count};
            `LSI_A_SAG_LVL: next_rdata = {16'h0000, sag_threshold};
            `LSI_A_VPK_LVL: next_rdata = {16'h0000, voltage_peak_level};
            `LSI_A_IPK_LVL: next_rdata = {16'h0000, current_peak_level};
            `LSI_A_VOLTAGE_PEAK_RECORD: next_rdata = voltage_peak_record;
            `LSI_A_VOLTAGE_PEAK_RECORD_RC: next_rdata = voltage_peak_record;
            `LSI_A_CURRENT_PEAK_RECORD: next_rdata = current_peak_record;
            `LSI_A_CURRENT_PEAK_RECORD_RC: next_rdata = current_peak_record;
            `LSI_A_PERIOD: next_rdata = {8'h00, line_period};
            default: next_rdata = {WAVE_W{1'b0}};
        endcase
    end

    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            reg_rdata <= {WAVE_W{1'b0}};
            rd_busy <= 1'b0;
            rd_addr <= {`LSI_ADDR_W{1'b0}};
            status_snap <= 16'h0000;
            rd_events <= 16'h0000;
        end else if (reg_rd) begin
            reg_rdata <= next_rdata;
            rd_busy <= 1'b1;
            rd_addr <= reg_addr;
            status_snap <= event_flags;
            // Same-cycle events are not in the snapshot
            rd_events <= event_set;
        end else begin
            // Accumulate until the next command; only read at the clear
            rd_events <= rd_events | event_set;
            if (reg_rd_done)
                rd_busy <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Timeout counter
    // ------------------------------------------------------------
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            div_cnt <= 7'h00;
            timeout_cnt <= `LSI_TIMEOUT_RST;
            timeout_active <= 1'b0;
        end else begin
            div_cnt <= div_cnt + 7'h01;
            if (crossing) begin
                timeout_cnt <= crossing_timeout;
                timeout_active <= 1'b0;
            end else if (tick_128 && timeout_cnt != {TIMEOUT_W{1'b0}}) begin
                timeout_cnt <= timeout_cnt - {{(TIMEOUT_W-1){1'b0}}, 1'b1};
                if (timeout_event)
                    timeout_active <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // Crossing indicator and period
    // ------------------------------------------------------------
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            prev_sign <= 1'b0;
            sign_seen <= 1'b0;
            crossing_indicator <= 1'b0;
            per_div <= 3'h0;
            per_cnt <= {(PERIOD_W-1){1'b0}};
            line_period <= {PERIOD_W{1'b0}};
        end else begin
            per_div <= per_div + 3'h1;
            if (vlp_valid) begin
                prev_sign <= lp_sign;
                sign_seen <= 1'b1;
            end
            if (crossing)
                crossing_indicator <= ~lp_sign;
            if (pos_crossing) begin
                line_period <= {1'b0, per_cnt};
                per_cnt <= {(PERIOD_W-1){1'b0}};
            end else if (per_tick && per_cnt != {(PERIOD_W-1){1'b1}}) begin
                per_cnt <= per_cnt + {{(PERIOD_W-2){1'b0}}, 1'b1};
            end
        end
    end

    // ------------------------------------------------------------
    // Sag detection
    // ------------------------------------------------------------
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            sag_cnt <= 8'h00;
            cyc_above <= 1'b0;
            sag_active <= 1'b0;
        end else begin
            if (lp_above) begin
                sag_cnt <= 8'h00;
                sag_active <= 1'b0;
            end
            if (pos_crossing) begin
                cyc_above <= 1'b0;
                if (cycle_low && !sag_active) begin
                    if (sag_event)
                        sag_active <= 1'b1;
                    else
                        sag_cnt <= next_sag_cnt;
                end
            end else if (lp_above) begin
                cyc_above <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // Peak records
    // ------------------------------------------------------------
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            voltage_peak_record <= {WAVE_W{1'b0}};
            current_peak_record <= {WAVE_W{1'b0}};
        end else begin
            // A sample taken in the clearing cycle is kept, not lost
            if (clr_voltage_peak_record)
                voltage_peak_record <= wave_valid ? v_dbl : {WAVE_W{1'b0}};
            else if (wave_valid && v_dbl > voltage_peak_record)
                voltage_peak_record <= v_dbl;
            if (clr_current_peak_record)
                current_peak_record <= wave_valid ? i_mag : {WAVE_W{1'b0}};
            else if (wave_valid && i_mag > current_peak_record)
                current_peak_record <= i_mag;
        end
    end

    // ------------------------------------------------------------
    // Flags and outputs
    // ------------------------------------------------------------
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            event_flags <= 16'h0000;
            irq_n <= 1'b1;
            sag_n <= 1'b1;
            energy_hold <= 1'b0;
        end else begin
            event_flags <= next_flags;
            irq_n <= hold_high | ~(|(next_flags & irq_enable));
            sag_n <= ~(supply_sync | (~sag_dis & (timeout_active | timeout_event
                     | sag_active | sag_event)));
            energy_hold <= supply_sync;
        end
    end

endmodule // lsi_top
`default_nettype wire

// >>> dv/lsi_checker_sva.sv
// Purpose: Port-level checker for the line supervision block
// Assumes: Single clock domain; helper state mirrors host writes
// Notes:   Bound from the bench top file
`timescale 1ns/1ps
`default_nettype none
module lsi_checker (
    input wire logic clk,
    input wire logic rstn,
    input wire logic [15:0] vlp_sample,
    input wire logic vlp_valid,
    input wire logic [23:0] v_sample,
    input wire logic wave_valid,
    input wire logic supply_low,
    input wire logic [5:0] reg_addr,
    input wire logic reg_wr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_rd,
    input wire logic reg_rd_done,
    input wire logic [23:0] reg_rdata,
    input wire logic irq_n,
    input wire logic sag_n,
    input wire logic crossing_indicator,
    input wire logic energy_hold
);
    // ----------------------------------------------------------------
    // Helper state
    // ----------------------------------------------------------------
    logic prev_neg, have_prev, mode_dis, in_read;
    logic [15:0] en;
    logic [7:0] vlvl;
    logic [23:0] vmag;
    assign vmag = v_sample[23] ? -v_sample : v_sample;
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            prev_neg <= 1'h0;
            have_prev <= 1'h0;
            mode_dis <= 1'h1;
            in_read <= 1'h0;
            en <= 16'h0040;
            vlvl <= 8'hFF;
        end else begin
            if (vlp_valid) prev_neg <= vlp_sample[15];
            if (vlp_valid) have_prev <= 1'h1;
            if (reg_wr && reg_addr == 6'h0A) en <= reg_wdata;
            if (reg_wr && reg_addr == 6'h20) vlvl <= reg_wdata[7:0];
            if (reg_wr && reg_addr == 6'h09) mode_dis <= reg_wdata[2];
            if (reg_rd && reg_addr == 6'h0C) in_read <= 1'h1;
            else if (reg_rd_done) in_read <= 1'h0;
        end
    end
    // ----------------------------------------------------------------
    // Properties
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);
    property p_irq_hold;
        reg_rd && reg_addr == 6'h0C |-> ##2 (irq_n throughout ##[0:40] reg_rd_done);
    endproperty
    a_irq_hold: assert property (p_irq_hold) else $error("irq_n low during status read");
    property p_peak_irq;
        wave_valid && !in_read && !reg_rd && en[8] && vmag[22:15] > vlvl |-> ##[1:2] !irq_n;
    endproperty
    a_peak_irq: assert property (p_peak_irq) else $error("peak event gave no irq");
    property p_energy_on;
        supply_low [*4] |=> energy_hold && !sag_n;
    endproperty
    a_energy_on: assert property (p_energy_on) else $error("low supply not held");
    property p_energy_off;
        !supply_low [*4] |=> !energy_hold;
    endproperty
    a_energy_off: assert property (p_energy_off) else $error("hold without low supply");
    property p_cross_pos;
        vlp_valid && have_prev && prev_neg && !vlp_sample[15] |-> ##[1:3] crossing_indicator;
    endproperty
    a_cross_pos: assert property (p_cross_pos) else $error("rising crossing missed");
    property p_cross_neg;
        vlp_valid && have_prev && !prev_neg && vlp_sample[15] |-> ##[1:3] !crossing_indicator;
    endproperty
    a_cross_neg: assert property (p_cross_neg) else $error("falling crossing missed");
    property p_period_msb;
        reg_rd && reg_addr == 6'h27 |=> ##1 reg_rdata[23:15] == 9'h000;
    endproperty
    a_period_msb: assert property (p_period_msb) else $error("period upper bits set");
    property p_tout_w;
        reg_rd && reg_addr == 6'h1D |=> ##1 reg_rdata[23:12] == 12'h000;
    endproperty
    a_tout_w: assert property (p_tout_w) else $error("timeout wider than 12 bits");
    property p_sag_dis;
        (mode_dis && !supply_low) [*4] |=> sag_n;
    endproperty
    a_sag_dis: assert property (p_sag_dis) else $error("sag low while disabled");
endmodule // lsi_checker
`default_nettype wire

// >>> dv/lsi_host.sv
// Purpose: Host model issuing framed register writes and reads
// Assumes: Drives on the falling edge, samples settled data
// Notes:   Released lines show the inverse of their last value
`timescale 1ns/1ps
`default_nettype none
module lsi_host (
    input wire logic clk,
    input wire logic [23:0] reg_rdata,
    output logic [5:0] reg_addr,
    output logic reg_wr,
    output logic [15:0] reg_wdata,
    output logic reg_rd,
    output logic reg_rd_done
);
    initial begin
        reg_addr = 6'h00;
        reg_wr = 1'h0;
        reg_wdata = 16'h0000;
        reg_rd = 1'h0;
        reg_rd_done = 1'h0;
    end
    task wr(input logic [5:0] a, input logic [15:0] d);
        @(negedge clk);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'h1;
        @(negedge clk);
        reg_wr = 1'h0;
        reg_addr = ~a;
        reg_wdata = ~d;
    endtask
    // Done comes a few cycles after the command, as a serial frame would
    task rd(input logic [5:0] a, output logic [23:0] d);
        @(negedge clk);
        reg_addr = a;
        reg_rd = 1'h1;
        @(negedge clk);
        reg_rd = 1'h0;
        @(negedge clk);
        d = reg_rdata;
        repeat (3) @(negedge clk);
        reg_rd_done = 1'h1;
        @(negedge clk);
        reg_rd_done = 1'h0;
        reg_addr = ~a;
    endtask
endmodule // lsi_host
`default_nettype wire

// >>> dv/lsi_top_bench.sv
// Purpose: Self-checking bench for the line supervision block
// Assumes: Inputs change on the falling edge
// Notes:   Register table rows first, event scenarios after
`timescale 1ns/1ps
`default_nettype none
module lsi_top_bench;
    typedef struct {logic w; logic [5:0] a; logic [15:0] d; logic [23:0] e;} lsi_row_t;
    reg clk = 1'h0;
    reg rstn = 1'h0;
    logic [15:0] vlp_sample = 16'h0000;
    logic vlp_valid = 1'h0;
    logic [23:0] v_sample = 24'h000000;
    logic [23:0] i_sample = 24'h000000;
    logic wave_valid = 1'h0;
    logic supply_low = 1'h0;
    wire [5:0] reg_addr;
    wire [15:0] reg_wdata;
    wire reg_wr, reg_rd, reg_rd_done, irq_n, sag_n, crossing_indicator, energy_hold;
    wire [23:0] reg_rdata;
    int n_mismatch = 0;
    int checks_done = 0;
    int t;
    logic [23:0] d;
    lsi_row_t rows [7] = '{
        '{1'h0, 6'h1D, 16'h0000, 24'h000FFF},
        '{1'h0, 6'h0A, 16'h0000, 24'h000040},
        '{1'h0, 6'h3F, 16'h0000, 24'h000000},
        '{1'h1, 6'h1D, 16'hF123, 24'h000123},
        '{1'h1, 6'h0A, 16'h0182, 24'h000182},
        '{1'h1, 6'h0C, 16'hFFFF, 24'h000000},
        '{1'h1, 6'h27, 16'h1234, 24'h000000}};
    always #4 clk = ~clk;
    lsi_top dut (.clk(clk), .rstn(rstn), .vlp_sample(vlp_sample), .vlp_valid(vlp_valid),
        .v_sample(v_sample), .i_sample(i_sample), .wave_valid(wave_valid),
        .supply_low(supply_low), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
        .reg_rd(reg_rd), .reg_rd_done(reg_rd_done), .reg_rdata(reg_rdata), .irq_n(irq_n),
        .sag_n(sag_n), .crossing_indicator(crossing_indicator), .energy_hold(energy_hold));
    lsi_host host (.clk(clk), .reg_rdata(reg_rdata), .reg_addr(reg_addr), .reg_wr(reg_wr),
        .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rd_done(reg_rd_done));
    task chk(input string what, input logic [23:0] e, input logic [23:0] g);
        checks_done++;
        if (g !== e) begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %h seen %h", what, e, g);
        end
    endtask
    task vlp(input logic [15:0] s);
        @(negedge clk);
        vlp_sample = s;
        vlp_valid = 1'h1;
        @(negedge clk);
        vlp_valid = 1'h0;
        vlp_sample = ~s;
        repeat (6) @(negedge clk);
    endtask
    task wave(input logic [23:0] v, input logic [23:0] i);
        @(negedge clk);
        v_sample = v;
        i_sample = i;
        wave_valid = 1'h1;
        @(negedge clk);
        wave_valid = 1'h0;
        v_sample = ~v;
        i_sample = ~i;
        repeat (6) @(negedge clk);
    endtask
    task final_report;
        $display("mismatches %0d checks %0d", n_mismatch, checks_done);
        if (n_mismatch == 0 && checks_done > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    // ----------------------------------------------------------------
    // Watchdog: the sequence needs well under 3000 cycles
    // ----------------------------------------------------------------
    initial begin
        #100000;
        n_mismatch++;
        final_report;
    end
    initial begin
        repeat (12) @(negedge clk);
        rstn = 1'h1;
        chk("irq_n reset", 24'h1, irq_n);
        foreach (rows[k]) begin
            if (rows[k].w) host.wr(rows[k].a, rows[k].d);
            host.rd(rows[k].a, d);
            chk("register row", rows[k].e, d);
        end
        // ------------------------------------------------------------
        // Peaks, records and read-clear
        // ------------------------------------------------------------
        host.wr(6'h20, 16'h0010);
        wave(24'hF00000, 24'h080000);
        chk("irq_n peak", 24'h0, irq_n);
        host.rd(6'h0B, d);
        chk("peak flags", 24'h000100, d);
        host.rd(6'h22, d);
        chk("voltage record", 24'h200000, d);
        host.rd(6'h24, d);
        chk("current record", 24'h080000, d);
        host.rd(6'h23, d);
        chk("voltage read clear", 24'h200000, d);
        host.rd(6'h22, d);
        chk("voltage cleared", 24'h000000, d);
        // Event lands between command and data end of a status read
        fork
            host.rd(6'h0C, d);
            begin
                repeat (2) @(negedge clk);
                wave(24'hF00000, 24'h000000);
            end
        join
        chk("status snapshot", 24'h000100, d);
        repeat (2) @(negedge clk);
        chk("irq_n pending", 24'h0, irq_n);
        host.rd(6'h0C, d);
        chk("kept event", 24'h000100, d);
        chk("irq_n released", 24'h1, irq_n);
        // ------------------------------------------------------------
        // Sag by cycle count, then release
        // ------------------------------------------------------------
        host.wr(6'h09, 16'h0000);
        host.wr(6'h1F, 16'h0040);
        host.wr(6'h1E, 16'h0003);
        for (int k = 0; k < 5; k++) begin
            vlp(16'h0100);
            if (k > 0) chk("indicator high", 24'h1, crossing_indicator);
            vlp(16'hFF00);
            chk("indicator low", 24'h0, crossing_indicator);
        end
        chk("sag_n sag", 24'h0, sag_n);
        chk("irq_n sag", 24'h0, irq_n);
        host.rd(6'h0C, d);
        chk("sag flag", 24'h1, d[1]);
        host.rd(6'h27, d);
        chk("period msb", 24'h0, d[15]);
        chk("period measured", 24'h1, |d);
        vlp(16'h3000);
        chk("sag_n release", 24'h1, sag_n);
        // ------------------------------------------------------------
        // Zero-crossing timeout, then supply monitor
        // ------------------------------------------------------------
        host.wr(6'h1D, 16'h0002);
        host.wr(6'h0A, 16'h0008);
        host.rd(6'h0C, d);
        vlp(16'hFF00);
        for (t = 0; t < 400 && sag_n !== 1'h0; t++) @(negedge clk);
        chk("timeout span", 24'h1, t >= 120 && t < 400);
        chk("irq_n timeout", 24'h0, irq_n);
        host.rd(6'h0C, d);
        chk("timeout flag", 24'h1, d[3]);
        supply_low = 1'h1;
        repeat (6) @(negedge clk);
        chk("energy hold", 24'h1, energy_hold);
        chk("sag_n supply", 24'h0, sag_n);
        supply_low = 1'h0;
        repeat (6) @(negedge clk);
        chk("energy run", 24'h0, energy_hold);
        final_report;
    end
endmodule // lsi_top_bench
bind lsi_top lsi_checker chk_i (.clk(clk), .rstn(rstn), .vlp_sample(vlp_sample),
    .vlp_valid(vlp_valid), .v_sample(v_sample), .wave_valid(wave_valid),
    .supply_low(supply_low), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
    .reg_rd(reg_rd), .reg_rd_done(reg_rd_done), .reg_rdata(reg_rdata), .irq_n(irq_n),
    .sag_n(sag_n), .crossing_indicator(crossing_indicator), .energy_hold(energy_hold));
`default_nettype wire

// >>> include/lsi_defs.vh
// Purpose: Constants for the line supervision and interrupt block
// Assumes: Registers are reached by a framed serial command port
// Notes:   Offsets are register addresses as seen by the host
//
// Operation
// - 12-bit timeout counter decrements every 128 clocks
// - Voltage zero crossing reloads the programmed timeout
// - Programmed timeout defaults to 0xFFF
// - Timeout expiry drives sag output low unless disabled
// - Expiry always flags; interrupt only when enabled
// - Timeout setting is read/write at address 1Dh
// - Line period 16 bits, updated each period, MSB zero
// - Supply undervoltage stops energy, holds sag low
// - Sag cycle count is one more than cycles
// - Completed sag flags, drives sag low, may interrupt
// - Sag output releases when voltage exceeds sag level
// - Sag level compared to doubled sample's top byte
// - Sag level zero or one means threshold zero
// - Both channels' doubled sample top bytes compared with peak levels
// - Peak exceeded sets its flag, interrupts if enabled
// - Two 24-bit peak records keep largest magnitude
// - Voltage record holds twice, current record direct
// - Reset-on-read peak read returns then clears
// - Flags set regardless; interrupt if flag enabled
// - Status read at 0x0C clears flags, releases interrupt
// - Events during status read kept, re-assert after
// - Interrupt enable at 0x0A gates peak events
// - Interrupt high from status read command end to data end
// - Crossing indicator high positive, low negative going
`ifndef LSI_DEFS_VH
`define LSI_DEFS_VH

// ----------------------------------------------------------------
// Register addresses
// ----------------------------------------------------------------
`define LSI_ADDR_W 6
`define LSI_A_MODE 6'h09
`define LSI_A_IRQ_ENABLE 6'h0A
`define LSI_A_EVENT_FLAGS 6'h0B
`define LSI_A_STATUS_RC 6'h0C
`define LSI_A_TIMEOUT 6'h1D
`define LSI_A_SAG_CYC 6'h1E
`define LSI_A_SAG_LVL 6'h1F
`define LSI_A_VPK_LVL 6'h20
`define LSI_A_IPK_LVL 6'h21
`define LSI_A_VOLTAGE_PEAK_RECORD 6'h22
`define LSI_A_VOLTAGE_PEAK_RECORD_RC 6'h23
`define LSI_A_CURRENT_PEAK_RECORD 6'h24
`define LSI_A_CURRENT_PEAK_RECORD_RC 6'h25
`define LSI_A_PERIOD 6'h27

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define LSI_MODE_SAG_DIS 2
`define LSI_BIT_SAG 1
`define LSI_BIT_TIMEOUT 3
`define LSI_BIT_CROSSING 4
`define LSI_BIT_CURRENT_PEAK_RECORD 7
`define LSI_BIT_VOLTAGE_PEAK_RECORD 8

// ----------------------------------------------------------------
// Reset values and timing
// ----------------------------------------------------------------
`define LSI_TIMEOUT_RST 12'hFFF
`define LSI_MODE_RST 16'h000C
`define LSI_IRQ_ENABLE_RST 16'h0040
`define LSI_SAG_CYC_RST 8'hFF
`define LSI_SAG_LVL_RST 8'h00
`define LSI_PK_LVL_RST 8'hFF
`define LSI_TIMEOUT_DIV 128
`define LSI_PERIOD_DIV 8

`endif
